// ### icam_regs.vh
`ifndef ICAM_REGS_VH
`define ICAM_REGS_VH

// register indices; byte address is four times the index
`define ICAM_IDX_RXB 10'h28B
`define ICAM_IDX_TXB 10'h28C
`define ICAM_IDX_CNT 10'h28D
`define ICAM_IDX_ADB0 10'h28E
`define ICAM_IDX_ADB1 10'h28F
`define ICAM_IDX_ADR0 10'h290
`define ICAM_IDX_ADR1 10'h291
`define ICAM_IDX_ADR2 10'h292
`define ICAM_IDX_ADR3 10'h293
`define ICAM_IDX_CON0 10'h294
`define ICAM_IDX_CON1 10'h295
`define ICAM_IDX_CON2 10'h296
`define ICAM_IDX_ERR 10'h297
`define ICAM_IDX_STAT0 10'h298
`define ICAM_IDX_STAT1 10'h299
`define ICAM_IDX_EVFLG 10'h29A
`define ICAM_IDX_EVEN 10'h29B
`define ICAM_IDX_CLK 10'h29C
`define ICAM_IDX_BTO 10'h29D
`define ICAM_IDX_EVCLR 10'h29E

// reset values
`define ICAM_ADR02_RST 8'hFF
`define ICAM_ADR13_RST 8'hFE
`define ICAM_TXB_RST 8'h00

// control and status fields
`define ICAM_CON0_EN 7
`define ICAM_STAT0_BFRE 7
`define ICAM_STAT0_SMA 6
`define ICAM_STAT0_RW 4
`define ICAM_STAT0_DATA 3
`define ICAM_STAT1_TXBE 5
`define ICAM_STAT1_CLRBF 2
`define ICAM_STAT1_RXBF 0

// event flag positions
`define ICAM_EV_SC 0
`define ICAM_EV_RSC 1
`define ICAM_EV_PC 2
`define ICAM_EV_ADR 3
`define ICAM_EV_WR 4
`define ICAM_EV_ACKT 6
`define ICAM_EV_CNT 7

// operating modes
`define ICAM_MODE_7 3'h0
`define ICAM_MODE_7M 3'h1
`define ICAM_MODE_10 3'h2
`define ICAM_MODE_10M 3'h3
`define ICAM_MODE_MH 3'h6
`define ICAM_MODE_MHM 3'h7

// bus answers
`define ICAM_RESP_OKAY 2'h0
`define ICAM_RESP_DECERR 2'h3

`endif

// ### icam_top.v
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "icam_regs.vh"

module icam_top (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // register bus write
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // register bus read
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // i2c pins
   input wire sclIn,
   input wire sdaIn,
   output reg sdaOut,
   output reg sdaOe_n,
   // interrupt
   output reg irq
);

   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_ADDR = 3'd1;
   localparam [2:0] ST_ADR2 = 3'd2;
   localparam [2:0] ST_WDATA = 3'd3;
   localparam [2:0] ST_RDATA = 3'd4;

   // bus holding registers
   reg awHeld_r, wHeld_r;
   reg [11:0] awAddr_r;
   reg [7:0] wByte_r;
   reg wStrb_r;
   // software registers
   reg [7:0] con0_r, con1_r, con2_r, err_r, clkSel_r, btoSel_r;
   reg [7:0] adr0_r, adr1_r, adr2_r, adr3_r;
   reg [7:0] txBuf_r, cnt_r, evEn_r;
   reg txbe_r, rxbf_r;
   // engine
   reg [1:0] sclSync_r, sdaSync_r;
   reg sclD_r, sdaD_r;
   reg [2:0] state_r, nextSt_r;
   reg ackPh_r, mAck_r, rw_r, tenHit_r, hiA_r;
   reg [3:0] bitCnt_r;
   reg [7:0] shift_r, txShift_r, rxBuf_r, adb0_r, adb1_r;
   reg evSc_r, evRsc_r, evPc_r, evAdr_r, evRx_r, evTx_r, evAck_r;
   wire [7:0] evFlags;

   // ---------------- register bus ----------------
   wire wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
   wire [9:0] wrIdx = awAddr_r[11:2];
   wire wrAligned = (awAddr_r[1:0] == 2'b00);
   wire wrMapped = wrAligned && wrIdx >= `ICAM_IDX_RXB && wrIdx <= `ICAM_IDX_EVCLR;
   wire wrEn = wrFire && wrMapped && wStrb_r;
   wire rdFire = s_axi_arvalid && s_axi_arready;
   wire [9:0] rdIdx = s_axi_araddr[11:2];
   wire rdAligned = (s_axi_araddr[1:0] == 2'b00);

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ICAM_RESP_OKAY;
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 12'h000;
         wByte_r <= 8'h00;
         wStrb_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_r <= s_axi_awaddr;
            awHeld_r <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wByte_r <= s_axi_wdata[7:0];
            wStrb_r <= s_axi_wstrb[0];
            wHeld_r <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? `ICAM_RESP_OKAY : `ICAM_RESP_DECERR;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
         end
         // ready returns only after the answer is taken: one write at a time
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   reg [7:0] rdByte;
   reg rdHit;
   always @* begin
      rdHit = rdAligned;
      rdByte = 8'h00;
      case (rdIdx)
         `ICAM_IDX_RXB: rdByte = rxBuf_r;
         `ICAM_IDX_TXB: rdByte = 8'h00;
         `ICAM_IDX_CNT: rdByte = cnt_r;
         `ICAM_IDX_ADB0: rdByte = adb0_r;
         `ICAM_IDX_ADB1: rdByte = adb1_r;
         `ICAM_IDX_ADR0: rdByte = adr0_r;
         `ICAM_IDX_ADR1: rdByte = adr1_r;
         `ICAM_IDX_ADR2: rdByte = adr2_r;
         `ICAM_IDX_ADR3: rdByte = adr3_r;
         `ICAM_IDX_CON0: rdByte = con0_r;
         `ICAM_IDX_CON1: rdByte = con1_r;
         `ICAM_IDX_CON2: rdByte = con2_r;
         `ICAM_IDX_ERR: rdByte = err_r;
         `ICAM_IDX_STAT0: begin
            rdByte[`ICAM_STAT0_BFRE] = (state_r == ST_IDLE) && sclD_r && sdaD_r;
            rdByte[`ICAM_STAT0_SMA] = (state_r != ST_IDLE);
            rdByte[`ICAM_STAT0_RW] = rw_r;
            rdByte[`ICAM_STAT0_DATA] = (state_r == ST_WDATA) || (state_r == ST_RDATA);
         end
         `ICAM_IDX_STAT1: begin
            rdByte[`ICAM_STAT1_TXBE] = txbe_r;
            rdByte[`ICAM_STAT1_RXBF] = rxbf_r;
         end
         `ICAM_IDX_EVFLG: rdByte = evFlags;
         `ICAM_IDX_EVEN: rdByte = evEn_r;
         `ICAM_IDX_CLK: rdByte = clkSel_r;
         `ICAM_IDX_BTO: rdByte = btoSel_r;
         `ICAM_IDX_EVCLR: rdByte = 8'h00;
         default: rdHit = 1'b0;
      endcase
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ICAM_RESP_OKAY;
      end else begin
         if (rdFire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rdHit ? rdByte : 8'h00};
            s_axi_rresp <= rdHit ? `ICAM_RESP_OKAY : `ICAM_RESP_DECERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ---------------- software registers ----------------
   wire rdRxb = rdFire && rdAligned && rdIdx == `ICAM_IDX_RXB;
   wire clrBuf = wrEn && wrIdx == `ICAM_IDX_STAT1 && wByte_r[`ICAM_STAT1_CLRBF];
   wire cntWr = wrEn && wrIdx == `ICAM_IDX_CNT;
   wire evByte = evRx_r || evTx_r;
   wire evCnt = evByte && !cntWr && cnt_r == 8'h01;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         con0_r <= 8'h00;
         con1_r <= 8'h00;
         con2_r <= 8'h00;
         err_r <= 8'h00;
         clkSel_r <= 8'h00;
         btoSel_r <= 8'h00;
         adr0_r <= `ICAM_ADR02_RST;
         adr1_r <= `ICAM_ADR13_RST;
         adr2_r <= `ICAM_ADR02_RST;
         adr3_r <= `ICAM_ADR13_RST;
         txBuf_r <= `ICAM_TXB_RST;
         cnt_r <= 8'h00;
         evEn_r <= 8'h00;
         txbe_r <= 1'b1;
         rxbf_r <= 1'b0;
      end else begin
         if (wrEn) begin
            case (wrIdx)
               `ICAM_IDX_TXB: txBuf_r <= wByte_r;
               `ICAM_IDX_ADR0: adr0_r <= wByte_r;
               `ICAM_IDX_ADR1: adr1_r <= {wByte_r[7:1], 1'b0};
               `ICAM_IDX_ADR2: adr2_r <= wByte_r;
               `ICAM_IDX_ADR3: adr3_r <= {wByte_r[7:1], 1'b0};
               `ICAM_IDX_CON0: con0_r <= wByte_r;
               `ICAM_IDX_CON1: con1_r <= wByte_r;
               `ICAM_IDX_CON2: con2_r <= wByte_r;
               `ICAM_IDX_ERR: err_r <= wByte_r;
               `ICAM_IDX_EVEN: evEn_r <= wByte_r;
               `ICAM_IDX_CLK: clkSel_r <= wByte_r;
               `ICAM_IDX_BTO: btoSel_r <= wByte_r;
               default: ; // receive buffer and capture registers keep their value
            endcase
         end
         if (cntWr)
            cnt_r <= wByte_r;
         else if (evByte && cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
         // hardware event wins over a same-cycle software clear
         if (evRx_r)
            rxbf_r <= 1'b1;
         else if (rdRxb || clrBuf)
            rxbf_r <= 1'b0;
         if (evTx_r || clrBuf)
            txbe_r <= 1'b1;
         else if (wrEn && wrIdx == `ICAM_IDX_TXB)
            txbe_r <= 1'b0;
      end
   end

   // ---------------- event flags and interrupt ----------------
   wire [7:0] evSet = {evCnt, evAck_r, 1'b0, evRx_r, evAdr_r, evPc_r, evRsc_r, evSc_r};
   wire [7:0] evClr = (wrEn && wrIdx == `ICAM_IDX_EVCLR) ? wByte_r : 8'h00;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : flagBit
         reg flag_r;
         always @(posedge clock or negedge reset_n) begin
            if (!reset_n)
               flag_r <= 1'b0;
            else if (evSet[g])
               flag_r <= 1'b1;
            else if (evClr[g])
               flag_r <= 1'b0;
         end
         assign evFlags[g] = flag_r;
      end
   endgenerate

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         irq <= 1'b0;
      else
         irq <= |(evFlags & evEn_r);
   end

   // ---------------- address comparison ----------------
   wire [2:0] mode = con0_r[2:0];
   wire enable = con0_r[`ICAM_CON0_EN];
   wire mode7u = (mode == `ICAM_MODE_7) || (mode == `ICAM_MODE_MH);
   wire mode7m = (mode == `ICAM_MODE_7M) || (mode == `ICAM_MODE_MHM);
   wire mode10 = (mode == `ICAM_MODE_10) || (mode == `ICAM_MODE_10M);
   // bit 0 is the R/W bit and never takes part in a 7-bit compare
   wire hit7u = (shift_r[7:1] == adr0_r[7:1]) ||
                (shift_r[7:1] == adr1_r[7:1]) ||
                (shift_r[7:1] == adr2_r[7:1]) ||
                (shift_r[7:1] == adr3_r[7:1]);
   wire hit7m = (((shift_r[7:1] ^ adr0_r[7:1]) & ~adr1_r[7:1]) == 7'h00) ||
                (((shift_r[7:1] ^ adr2_r[7:1]) & ~adr3_r[7:1]) == 7'h00);
   wire hit7 = (mode7u && hit7u) || (mode7m && hit7m);
   wire hiA = (shift_r[7:1] == adr1_r[7:1]);
   wire hiB = (shift_r[7:1] == adr3_r[7:1]);
   wire hiM = (shift_r[7:3] == adr1_r[7:3]) &&
              (((shift_r[2:1] ^ adr1_r[2:1]) & ~adr3_r[2:1]) == 2'b00);
   wire hiHit = (mode == `ICAM_MODE_10M) ? hiM : (hiA || hiB);
   wire loHit = (mode == `ICAM_MODE_10M) ?
                (((shift_r ^ adr0_r) & ~adr2_r) == 8'h00) :
                (hiA_r ? (shift_r == adr0_r) : (shift_r == adr2_r));

   // ---------------- link engine ----------------
   // first stage feeds only the second; edges come from stage two and its delay
   wire sclS = sclSync_r[1];
   wire sdaS = sdaSync_r[1];
   wire sclRise = sclS && !sclD_r;
   wire sclFall = !sclS && sclD_r;
   wire startCond = sclS && sclD_r && sdaD_r && !sdaS;
   wire stopCond = sclS && sclD_r && !sdaD_r && sdaS;

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sclSync_r <= 2'b11;
         sdaSync_r <= 2'b11;
         sclD_r <= 1'b1;
         sdaD_r <= 1'b1;
         sdaOut <= 1'b0;
      end else begin
         sclSync_r <= {sclSync_r[0], sclIn};
         sdaSync_r <= {sdaSync_r[0], sdaIn};
         sclD_r <= sclS;
         sdaD_r <= sdaS;
         sdaOut <= 1'b0; // open drain: only ever pulls low
      end
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         nextSt_r <= ST_IDLE;
         ackPh_r <= 1'b0;
         mAck_r <= 1'b0;
         rw_r <= 1'b0;
         tenHit_r <= 1'b0;
         hiA_r <= 1'b0;
         bitCnt_r <= 4'h0;
         shift_r <= 8'h00;
         txShift_r <= 8'h00;
         rxBuf_r <= 8'h00;
         adb0_r <= 8'h00;
         adb1_r <= 8'h00;
         sdaOe_n <= 1'b1;
         evSc_r <= 1'b0;
         evRsc_r <= 1'b0;
         evPc_r <= 1'b0;
         evAdr_r <= 1'b0;
         evRx_r <= 1'b0;
         evTx_r <= 1'b0;
         evAck_r <= 1'b0;
      end else begin
         evSc_r <= 1'b0;
         evRsc_r <= 1'b0;
         evPc_r <= 1'b0;
         evAdr_r <= 1'b0;
         evRx_r <= 1'b0;
         evTx_r <= 1'b0;
         evAck_r <= 1'b0;
         if (!enable) begin
            state_r <= ST_IDLE;
            ackPh_r <= 1'b0;
            tenHit_r <= 1'b0;
            sdaOe_n <= 1'b1;
         end else if (startCond) begin
            evRsc_r <= (state_r != ST_IDLE);
            evSc_r <= (state_r == ST_IDLE);
            state_r <= ST_ADDR;
            bitCnt_r <= 4'h0;
            ackPh_r <= 1'b0;
            sdaOe_n <= 1'b1;
         end else if (stopCond) begin
            evPc_r <= (state_r != ST_IDLE);
            state_r <= ST_IDLE;
            ackPh_r <= 1'b0;
            tenHit_r <= 1'b0;
            sdaOe_n <= 1'b1;
         end else if (state_r != ST_IDLE && sclRise) begin
            if (ackPh_r) begin
               if (state_r == ST_RDATA)
                  mAck_r <= !sdaS;
            end else begin
               bitCnt_r <= bitCnt_r + 4'h1;
               if (state_r != ST_RDATA)
                  shift_r <= {shift_r[6:0], sdaS};
            end
         end else if (state_r != ST_IDLE && sclFall) begin
            if (ackPh_r) begin
               ackPh_r <= 1'b0;
               bitCnt_r <= 4'h0;
               if (state_r == ST_RDATA && !mAck_r) begin
                  state_r <= ST_IDLE;
                  sdaOe_n <= 1'b1;
               end else begin
                  state_r <= nextSt_r;
                  if (nextSt_r == ST_RDATA) begin
                     txShift_r <= txBuf_r;
                     sdaOe_n <= txBuf_r[7];
                     evTx_r <= 1'b1;
                  end else begin
                     sdaOe_n <= 1'b1;
                  end
               end
            end else if (bitCnt_r == 4'h8) begin
               ackPh_r <= 1'b1;
               sdaOe_n <= 1'b1;
               nextSt_r <= ST_IDLE;
               case (state_r)
                  ST_ADDR: begin
                     if (mode10 && hiHit && (!shift_r[0] || tenHit_r)) begin
                        sdaOe_n <= 1'b0;
                        evAck_r <= 1'b1;
                        adb1_r <= shift_r;
                        rw_r <= shift_r[0];
                        hiA_r <= hiA;
                        nextSt_r <= shift_r[0] ? ST_RDATA : ST_ADR2;
                        evAdr_r <= shift_r[0];
                     end else if (!mode10 && hit7) begin
                        sdaOe_n <= 1'b0;
                        evAck_r <= 1'b1;
                        adb0_r <= shift_r;
                        rw_r <= shift_r[0];
                        nextSt_r <= shift_r[0] ? ST_RDATA : ST_WDATA;
                        evAdr_r <= 1'b1;
                     end
                  end
                  ST_ADR2: begin
                     if (loHit) begin
                        sdaOe_n <= 1'b0;
                        evAck_r <= 1'b1;
                        adb0_r <= shift_r;
                        tenHit_r <= 1'b1;
                        nextSt_r <= ST_WDATA;
                        evAdr_r <= 1'b1;
                     end
                  end
                  ST_WDATA: begin
                     // a full receive buffer refuses the byte rather than lose one
                     if (!rxbf_r) begin
                        sdaOe_n <= 1'b0;
                        evAck_r <= 1'b1;
                        rxBuf_r <= shift_r;
                        evRx_r <= 1'b1;
                        nextSt_r <= ST_WDATA;
                     end
                  end
                  default: nextSt_r <= ST_RDATA;
               endcase
            end else if (state_r == ST_RDATA) begin
               sdaOe_n <= txShift_r[6];
               txShift_r <= {txShift_r[6:0], 1'b0};
            end
         end
      end
   end

endmodule
`default_nettype wire

// ### icam_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "icam_regs.vh"
module icam_properties (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // i2c pins
   input wire logic sclIn,
   input wire logic sdaOe_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer not held");
   a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not held");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> !s_axi_awready ##[0:2] s_axi_bvalid) else $error("no write answer");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data above byte");
   a_txb_reads_zero: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == {`ICAM_IDX_TXB, 2'b00}
      |=> s_axi_rdata == 32'h00000000) else $error("transmit buffer read not zero");
   // data may only start to be pulled while the clock line is low
   a_drive_scl_low: assert property ($fell(sdaOe_n) |-> !sclIn)
      else $error("data pulled with clock high");
endmodule
bind icam_top icam_properties icam_properties_i (.clock, .reset_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclIn, .sdaOe_n);
`default_nettype wire

// ### icam_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module icam_host_model (
   // client pull on data
   input wire logic sdaOe_n,
   // bus lines
   output logic scl,
   output wire logic sda
);
   logic rel = 1'b1;
   initial scl = 1'b1;
   // open drain both ways; pull-up wins when nobody pulls
   assign sda = rel & sdaOe_n;
   task automatic bitIo(input logic b, output logic s);
      begin
         #100 rel = b;
         #100 scl = 1'b1;
         #100 s = sda;
         #100 scl = 1'b0;
      end
   endtask
   // odd offset keeps the link out of step with the system clock
   task automatic startCond;
      begin
         #113 rel = 1'b1;
         #100 scl = 1'b1;
         #200 rel = 1'b0;
         #200 scl = 1'b0;
      end
   endtask
   task automatic stopCond;
      begin
         #100 rel = 1'b0;
         #100 scl = 1'b1;
         #200 rel = 1'b1;
         #200;
      end
   endtask
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic s;
      begin
         for (int i = 7; i >= 0; i--) bitIo(d[i], s);
         bitIo(1'b1, s);
         ack = ~s;
      end
   endtask
   // host reads one byte and answers with a release, which ends the read
   task automatic recvByte(output logic [7:0] d);
      logic s;
      begin
         for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, s);
            d[i] = s;
         end
         bitIo(1'b1, s);
      end
   endtask
endmodule
`default_nettype wire

// ### test_i2c_client_address_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "icam_regs.vh"
module test_i2c_client_address_match;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire sclIn, sdaIn, sdaOut, sdaOe_n, irq;
   logic [31:0] expQ[$];
   integer seed = 80;
   int badCount = 0, compares = 0, cycles = 0;
   icam_top icam_top_i (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclIn, .sdaIn, .sdaOut,
      .sdaOe_n, .irq);
   icam_host_model icam_host_model_i (.sdaOe_n, .scl(sclIn), .sda(sdaIn));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         badCount++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic printVerdict;
      $display("compares %0d bad %0d", compares, badCount);
      if (badCount == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [31:0] okv(input logic [7:0] b);
      return {24'h000000, b};
   endfunction
   // expected answer is {resp, 30 low bits of data}
   task automatic axiWrite(input logic [9:0] idx, input logic [7:0] d,
      input logic [31:0] exp = 32'h0);
      @(posedge clock);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      expQ.push_back(exp);
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axiRead(input logic [9:0] idx, input logic [31:0] exp);
      @(posedge clock);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      expQ.push_back(exp);
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // one frame: address (with low byte when lo[8]), one data byte when expAck, stop
   task automatic tx(input logic [7:0] hdr, input logic [8:0] lo, input logic expAck);
      logic ack;
      logic [7:0] d;
      d = 8'($random(seed));
      icam_host_model_i.startCond;
      icam_host_model_i.sendByte(hdr, ack);
      if (lo[8] && ack) icam_host_model_i.sendByte(lo[7:0], ack);
      check("addrAck", {31'h0, ack}, {31'h0, expAck});
      if (expAck) begin
         icam_host_model_i.sendByte(d, ack);
         check("dataAck", {31'h0, ack}, 32'h1);
      end
      icam_host_model_i.stopCond;
      if (expAck) begin
         axiRead(`ICAM_IDX_ADB0, okv(lo[8] ? lo[7:0] : hdr));
         axiRead(`ICAM_IDX_RXB, okv(d));
      end
   endtask
   task automatic irqIs(input logic v);
      repeat (2) @(posedge clock);
      check("irq", {31'h0, irq}, {31'h0, v});
      check("sdaOut", {31'h0, sdaOut}, 32'h0);
   endtask
   initial begin
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (s_axi_rvalid && s_axi_rready)
         check("rdata", {s_axi_rresp, s_axi_rdata[29:0]}, expQ.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         check("bresp", {s_axi_bresp, 30'h0}, expQ.pop_front());
      if (cycles == 20000) begin
         badCount++;
         printVerdict;
      end
   end
   initial begin
      logic [6:0] r;
      logic [7:0] lo;
      logic [1:0] hi;
      logic ack;
      logic [7:0] got;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      axiRead(`ICAM_IDX_ADR0, okv(8'hFF));
      axiRead(`ICAM_IDX_ADR1, okv(8'hFE));
      axiRead(`ICAM_IDX_ADR2, okv(8'hFF));
      axiRead(`ICAM_IDX_ADR3, okv(8'hFE));
      axiRead(`ICAM_IDX_STAT1, okv(8'h20));
      axiWrite(`ICAM_IDX_TXB, 8'($random(seed)));
      axiRead(`ICAM_IDX_TXB, okv(8'h00));
      axiWrite(`ICAM_IDX_RXB, 8'h5A);
      axiRead(`ICAM_IDX_RXB, okv(8'h00));
      axiWrite(10'h3FF, 8'h11, 32'hC0000000);
      axiRead(10'h3FF, 32'hC0000000);
      $display("done registers");
      for (int m = 0; m < 2; m++) begin
         r = {2'b01, 5'($random(seed))};
         axiWrite(`ICAM_IDX_ADR0, {r, 1'b1});
         axiWrite(`ICAM_IDX_ADR1, {r ^ 7'h01, 1'b0});
         axiWrite(`ICAM_IDX_ADR2, {r ^ 7'h02, 1'b1});
         axiWrite(`ICAM_IDX_ADR3, {r ^ 7'h04, 1'b0});
         axiWrite(`ICAM_IDX_CON0, m ? 8'h86 : 8'h80);
         for (int k = 0; k < 4; k++)
            tx({r ^ 7'((1 << k) >> 1), 1'b0}, 9'h000, 1'b1);
         tx({r ^ 7'h07, 1'b0}, 9'h000, 1'b0);
      end
      $display("done seven bit");
      axiWrite(`ICAM_IDX_EVCLR, 8'hFF);
      axiWrite(`ICAM_IDX_EVEN, 8'h08);
      irqIs(1'b0);
      tx({r, 1'b0}, 9'h000, 1'b1);
      irqIs(1'b1);
      axiWrite(`ICAM_IDX_EVCLR, 8'h08);
      irqIs(1'b0);
      axiWrite(`ICAM_IDX_EVEN, 8'h00);
      tx({r, 1'b0}, 9'h000, 1'b1);
      irqIs(1'b0);
      axiWrite(`ICAM_IDX_EVEN, 8'h08);
      irqIs(1'b1);
      $display("done interrupt");
      lo = 8'($random(seed));
      axiWrite(`ICAM_IDX_TXB, lo);
      icam_host_model_i.startCond;
      icam_host_model_i.sendByte({r, 1'b1}, ack);
      icam_host_model_i.recvByte(got);
      icam_host_model_i.stopCond;
      check("readAck", {31'h0, ack}, 32'h1);
      check("txByte", {24'h0, got}, {24'h0, lo});
      axiRead(`ICAM_IDX_ADB0, okv({r, 1'b1}));
      $display("done read");
      for (int m = 0; m < 2; m++) begin
         r = {2'b01, 5'($random(seed))};
         axiWrite(`ICAM_IDX_CON0, m ? 8'h87 : 8'h81);
         axiWrite(`ICAM_IDX_ADR0, {r, 1'b0});
         axiWrite(`ICAM_IDX_ADR1, 8'h10);
         axiWrite(`ICAM_IDX_ADR2, {r ^ 7'h10, 1'b0});
         axiWrite(`ICAM_IDX_ADR3, 8'h02);
         tx({r ^ 7'h08, 1'b0}, 9'h000, 1'b1);
         tx({r ^ 7'h11, 1'b0}, 9'h000, 1'b1);
         tx({r ^ 7'h04, 1'b0}, 9'h000, 1'b0);
      end
      $display("done masked");
      lo = 8'($random(seed));
      hi = 2'($random(seed));
      axiWrite(`ICAM_IDX_CON0, 8'h82);
      axiWrite(`ICAM_IDX_ADR0, lo);
      axiWrite(`ICAM_IDX_ADR1, {5'b11110, hi, 1'b0});
      axiWrite(`ICAM_IDX_ADR2, ~lo);
      axiWrite(`ICAM_IDX_ADR3, {5'b11110, ~hi, 1'b0});
      tx({5'b11110, hi, 1'b0}, {1'b1, lo}, 1'b1);
      tx({5'b11110, ~hi, 1'b0}, {1'b1, ~lo}, 1'b1);
      tx({5'b11100, hi, 1'b0}, {1'b1, lo}, 1'b0);
      axiWrite(`ICAM_IDX_CON0, 8'h83);
      axiWrite(`ICAM_IDX_ADR2, 8'h01);
      axiWrite(`ICAM_IDX_ADR3, 8'h04);
      tx({5'b11110, hi ^ 2'b10, 1'b0}, {1'b1, lo ^ 8'h01}, 1'b1);
      $display("done ten bit");
      printVerdict;
   end
endmodule
`default_nettype wire
